/* pdwc_core_model.sv */
// Core-side model issuing halt and clear-watchdog strobes
`timescale 1ns/100ps
`include "pdwc_regs.vh"
module pdwc_core_model (
  // Clock
  input wire ref_clk,
  // Strobes
  output reg halt_exec,
  output reg clr_wdt_exec,
  output reg [`PDWC_PC_WIDTH-1:0] halt_pc
);
  initial begin
    halt_exec = 1'b0;
    clr_wdt_exec = 1'b0;
    halt_pc = 12'h000;
  end
  task halt(input [`PDWC_PC_WIDTH-1:0] pc);
    begin
      @(posedge ref_clk) #1;
      halt_pc = pc;
      halt_exec = 1'b1;
      @(posedge ref_clk) #1;
      halt_exec = 1'b0;
      // The core moves on, so the old address must not linger
      halt_pc = ~pc;
    end
  endtask
  task clr_wdt;
    begin
      @(posedge ref_clk) #1;
      clr_wdt_exec = 1'b1;
      @(posedge ref_clk) #1;
      clr_wdt_exec = 1'b0;
    end
  endtask
endmodule

/* pdwc_ctrl.v */
// Power-down mode selection, clock gating and wake-up control
`timescale 1ns/100ps
`include "pdwc_regs.vh"
// How it works
// RQ1: Halt, idle off, watchdog off: full stop
// RQ2: Full stop clears and freezes watchdog counter
// RQ3: Halt, idle off, watchdog on: watchdog sleep
// RQ4: Other modes clear watchdog, keep counting if enabled
// RQ5: Idle select, keep bit low: clock-off idle
// RQ6: Idle select, keep bit high: clock-on idle
// RQ7: Low-power modes keep memory, registers, ports
// RQ8: Halt sets powerdown flag, clears timeout flag
// RQ9: Wake on reset, port A, interrupt, watchdog
// RQ10: External reset wake gives full reset
// RQ11: Watchdog wake sets timeout, resets PC, SP
// RQ12: Powerdown flag cleared by power-up, clear-watchdog
// RQ13: Per-pin wake enable for port A falls
// RQ14: Port A wake resumes after the halt
// RQ15: Disabled interrupt wake resumes, serviced later
// RQ16: Already-pending interrupt cannot wake the device
// RQ17: Enabled interrupt with stack room: take response
// RQ18: Idle mode chosen by keep bit only
module pdwc_ctrl (
  // Clock and reset
  input wire ref_clk,
  input wire arst_n,
  // Core strobes
  input wire halt_exec,
  input wire clr_wdt_exec,
  // Mode configuration
  input wire idle_select,
  input wire idle_clock_keep,
  input wire wdt_enable,
  // Wake sources
  input wire [`PDWC_PA_WIDTH-1:0] porta_pin,
  input wire [`PDWC_PA_WIDTH-1:0] porta_wake_enable,
  input wire [`PDWC_INT_WIDTH-1:0] int_request,
  input wire [`PDWC_INT_WIDTH-1:0] int_enable,
  input wire stack_full,
  input wire wdt_tick,
  // Program counter of the halt
  input wire [`PDWC_PC_WIDTH-1:0] halt_pc,
  // Mode and clock gating
  output reg full_stop_sleep,
  output reg watchdog_running_sleep,
  output reg clock_off_idle,
  output reg clock_on_idle,
  output reg sys_clk_en,
  output reg wdt_clk_en,
  output reg tb_clk_en,
  output reg core_hold,
  output reg state_hold,
  // Watchdog and status
  output reg [`PDWC_WDT_WIDTH-1:0] watchdog_counter,
  output reg wdt_overflow,
  output reg powerdown_flag,
  output reg watchdog_timeout_flag,
  // Resume control
  output reg resume_load,
  output reg [`PDWC_PC_WIDTH-1:0] resume_pc,
  output reg sp_reset,
  output reg [`PDWC_SP_WIDTH-1:0] sp_value,
  output reg int_take,
  output reg [`PDWC_INT_WIDTH-1:0] int_pending
);

////////////////////////////////////////////////////////////////////////
// States

localparam [4:0] ST_RUN = 5'h01;
localparam [4:0] ST_FULL_STOP_SLEEP = 5'h02;
localparam [4:0] ST_WATCHDOG_RUNNING_SLEEP = 5'h04;
localparam [4:0] ST_CLOCK_OFF_IDLE = 5'h08;
localparam [4:0] ST_CLOCK_ON_IDLE = 5'h10;

reg [4:0] state;
reg [4:0] next_state;
reg [`PDWC_PA_WIDTH-1:0] pa_prev;
reg [`PDWC_INT_WIDTH-1:0] int_armed;
wire [`PDWC_PA_WIDTH-1:0] pa_sync;

////////////////////////////////////////////////////////////////////////
// Port A pins arrive asynchronously

pdwc_sync #(
  .WIDTH(`PDWC_PA_WIDTH)
) u_pa_sync (
  .ref_clk(ref_clk),
  .arst_n(arst_n),
  .async_in(porta_pin),
  .sync_out(pa_sync)
);

wire [`PDWC_PA_WIDTH-1:0] pa_fall;
genvar gi;
generate
  for (gi = 0; gi < `PDWC_PA_WIDTH; gi = gi + 1) begin : g_pa
    assign pa_fall[gi] = pa_prev[gi] & ~pa_sync[gi] & porta_wake_enable[gi]; // [RQ13]
  end
endgenerate

wire asleep = (state != ST_RUN);
wire pa_wake = asleep && (|pa_fall);
// Only requests raised after entry may wake; old ones were disarmed at the halt
wire [`PDWC_INT_WIDTH-1:0] int_new = int_request & int_armed; // [RQ16]
wire int_wake = asleep && (|int_new);
wire wdt_counting = (state == ST_RUN || state != ST_FULL_STOP_SLEEP) && wdt_enable;
wire wdt_wrap = wdt_counting && wdt_tick && (&watchdog_counter);
wire wdt_wake = asleep && wdt_wrap;
wire any_wake = pa_wake || int_wake || wdt_wake; // [RQ9]
wire int_now = |(int_new & int_enable);

////////////////////////////////////////////////////////////////////////
// Mode selection on halt

always @* begin
  next_state = state;
  case (state)
    ST_RUN: begin
      if (halt_exec) begin
        if (idle_select) begin
          next_state = idle_clock_keep ? ST_CLOCK_ON_IDLE : ST_CLOCK_OFF_IDLE; // [RQ5] [RQ6] [RQ18]
        end else begin
          next_state = wdt_enable ? ST_WATCHDOG_RUNNING_SLEEP : ST_FULL_STOP_SLEEP; // [RQ1] [RQ3]
        end
      end
    end
    ST_FULL_STOP_SLEEP, ST_WATCHDOG_RUNNING_SLEEP, ST_CLOCK_OFF_IDLE, ST_CLOCK_ON_IDLE: begin
      if (any_wake) begin
        next_state = ST_RUN;
      end
    end
    default: begin
      next_state = ST_RUN;
    end
  endcase
end

always @(posedge ref_clk or negedge arst_n) begin
  if (!arst_n) begin
    state <= ST_RUN; // [RQ10]
    pa_prev <= {`PDWC_PA_WIDTH{1'b1}};
    int_armed <= {`PDWC_INT_WIDTH{1'b0}};
    int_pending <= {`PDWC_INT_WIDTH{1'b0}};
  end else begin
    state <= next_state;
    pa_prev <= pa_sync;
    if (state == ST_RUN && halt_exec) begin
      int_armed <= ~int_request; // [RQ16]
    end else if (!asleep) begin
      int_armed <= {`PDWC_INT_WIDTH{1'b0}};
    end
    // Requests that wake the device while none of them is enabled wait for enable and stack room
    if (int_wake && !int_now) begin
      int_pending <= int_pending | int_new; // [RQ15]
    end else if (int_take) begin
      int_pending <= {`PDWC_INT_WIDTH{1'b0}};
    end else if (!asleep && !stack_full) begin
      int_pending <= int_pending & ~int_enable; // [RQ15]
    end
  end
end

////////////////////////////////////////////////////////////////////////
// Clock gating and mode outputs

always @(posedge ref_clk or negedge arst_n) begin
  if (!arst_n) begin
    full_stop_sleep <= 1'b0;
    watchdog_running_sleep <= 1'b0;
    clock_off_idle <= 1'b0;
    clock_on_idle <= 1'b0;
    sys_clk_en <= 1'b1;
    wdt_clk_en <= 1'b1;
    tb_clk_en <= 1'b1;
    core_hold <= 1'b0;
    state_hold <= 1'b0;
  end else begin
    full_stop_sleep <= (next_state == ST_FULL_STOP_SLEEP);
    watchdog_running_sleep <= (next_state == ST_WATCHDOG_RUNNING_SLEEP);
    clock_off_idle <= (next_state == ST_CLOCK_OFF_IDLE);
    clock_on_idle <= (next_state == ST_CLOCK_ON_IDLE);
    sys_clk_en <= (next_state == ST_RUN) || (next_state == ST_CLOCK_ON_IDLE); // [RQ1] [RQ3] [RQ5] [RQ6]
    tb_clk_en <= (next_state == ST_RUN) || (next_state == ST_CLOCK_OFF_IDLE) || (next_state == ST_CLOCK_ON_IDLE); // [RQ5]
    wdt_clk_en <= (next_state != ST_FULL_STOP_SLEEP); // [RQ2] [RQ3]
    core_hold <= (next_state != ST_RUN); // [RQ1] [RQ6]
    // Memory, registers and ports are frozen, not reset, while held
    state_hold <= (next_state != ST_RUN); // [RQ7]
  end
end

////////////////////////////////////////////////////////////////////////
// Watchdog counter and flags

always @(posedge ref_clk or negedge arst_n) begin
  if (!arst_n) begin
    watchdog_counter <= `PDWC_WDT_CLEAR;
    wdt_overflow <= 1'b0;
    powerdown_flag <= `PDWC_PDF_RESET;
    watchdog_timeout_flag <= `PDWC_TOF_RESET;
  end else begin
    wdt_overflow <= wdt_wrap;
    if ((state == ST_RUN && halt_exec) || clr_wdt_exec) begin
      watchdog_counter <= `PDWC_WDT_CLEAR; // [RQ2] [RQ4]
    end else if (state == ST_FULL_STOP_SLEEP) begin
      watchdog_counter <= watchdog_counter; // [RQ2]
    end else if (wdt_counting && wdt_tick) begin
      watchdog_counter <= watchdog_counter + 1'b1; // [RQ4]
    end
    if (state == ST_RUN && halt_exec) begin
      powerdown_flag <= 1'b1; // [RQ8] [RQ12]
      watchdog_timeout_flag <= 1'b0; // [RQ8]
    end else begin
      if (clr_wdt_exec) begin
        powerdown_flag <= 1'b0; // [RQ12]
      end
      // A timeout in the same cycle as a clear still sets the flag
      if (wdt_wrap) begin
        watchdog_timeout_flag <= 1'b1; // [RQ11]
      end else if (clr_wdt_exec) begin
        watchdog_timeout_flag <= 1'b0;
      end
    end
  end
end

////////////////////////////////////////////////////////////////////////
// Resume control

always @(posedge ref_clk or negedge arst_n) begin
  if (!arst_n) begin
    resume_load <= 1'b0;
    resume_pc <= `PDWC_PC_RESET;
    sp_reset <= 1'b0;
    sp_value <= `PDWC_SP_RESET;
    int_take <= 1'b0;
  end else begin
    resume_load <= asleep && any_wake;
    sp_reset <= wdt_wake; // [RQ11]
    sp_value <= `PDWC_SP_RESET;
    // A request held back at wake is taken once enabled with stack room
    int_take <= (int_wake && !wdt_wake && int_now && !stack_full) || // [RQ17]
      (!asleep && !stack_full && (|(int_pending & int_enable))); // [RQ15]
    if (state == ST_RUN && halt_exec) begin
      resume_pc <= halt_pc + 1'b1; // [RQ14] [RQ15]
    end else if (wdt_wake) begin
      resume_pc <= `PDWC_PC_RESET; // [RQ11]
    end
  end
end

endmodule

/* pdwc_ctrl_checker.sv */
// Concurrent checks on the mode controller ports
`timescale 1ns/100ps
`include "pdwc_regs.vh"
module pdwc_ctrl_checker (
  // Clock, reset and strobes
  input wire ref_clk,
  input wire arst_n,
  input wire halt_exec,
  input wire clr_wdt_exec,
  // Mode configuration
  input wire idle_select,
  input wire idle_clock_keep,
  input wire wdt_enable,
  // Modes and clocks
  input wire full_stop_sleep,
  input wire watchdog_running_sleep,
  input wire clock_off_idle,
  input wire clock_on_idle,
  input wire sys_clk_en,
  input wire wdt_clk_en,
  input wire tb_clk_en,
  input wire core_hold,
  // Watchdog, status, resume
  input wire [`PDWC_WDT_WIDTH-1:0] watchdog_counter,
  input wire wdt_overflow,
  input wire powerdown_flag,
  input wire watchdog_timeout_flag,
  input wire resume_load
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // A halt counts only while running
  wire go = halt_exec && !core_hold;
  AST_FULL_STOP: assert property (go && !idle_select && !wdt_enable |=> full_stop_sleep && !sys_clk_en && !wdt_clk_en && !tb_clk_en)
    else $error("full stop entry wrong");
  AST_WDT_SLEEP: assert property (go && !idle_select && wdt_enable |=> watchdog_running_sleep && !sys_clk_en && wdt_clk_en && !tb_clk_en)
    else $error("watchdog sleep entry wrong");
  AST_IDLE_OFF: assert property (go && idle_select && !idle_clock_keep |=> clock_off_idle && !sys_clk_en && tb_clk_en)
    else $error("clock-off idle entry wrong");
  AST_IDLE_ON: assert property (go && idle_select && idle_clock_keep |=> clock_on_idle && sys_clk_en && tb_clk_en)
    else $error("clock-on idle entry wrong");
  AST_ENTRY_FLAGS: assert property (go |=> powerdown_flag && !watchdog_timeout_flag && watchdog_counter == 16'h0000)
    else $error("entry flags wrong");
  AST_COUNT_FROZEN: assert property (full_stop_sleep && $past(full_stop_sleep) |-> watchdog_counter == 16'h0000)
    else $error("counter moved in full stop");
  AST_PDF_CLEAR: assert property (clr_wdt_exec && !halt_exec |=> !powerdown_flag)
    else $error("powerdown flag not cleared");
  AST_WRAP_FLAG: assert property (wdt_overflow && !$past(halt_exec) |-> watchdog_timeout_flag)
    else $error("timeout flag missing");
  AST_WAKE_EXIT: assert property (resume_load |-> !core_hold && $past(core_hold))
    else $error("resume without wake");
endmodule

bind pdwc_ctrl pdwc_ctrl_checker i_chk (.ref_clk, .arst_n, .halt_exec, .clr_wdt_exec, .idle_select, .idle_clock_keep,
  .wdt_enable, .full_stop_sleep, .watchdog_running_sleep, .clock_off_idle, .clock_on_idle, .sys_clk_en, .wdt_clk_en,
  .tb_clk_en, .core_hold, .watchdog_counter, .wdt_overflow, .powerdown_flag, .watchdog_timeout_flag, .resume_load);

/* pdwc_regs.vh */
// Constants for the power-down mode and wake-up controller
`ifndef PDWC_REGS_VH
`define PDWC_REGS_VH

`define PDWC_PA_WIDTH 8
`define PDWC_INT_WIDTH 4
`define PDWC_WDT_WIDTH 16
`define PDWC_PC_WIDTH 12
`define PDWC_SP_WIDTH 3
`define PDWC_PC_RESET 12'h000
`define PDWC_SP_RESET 3'h0
`define PDWC_WDT_CLEAR 16'h0000
`define PDWC_PDF_RESET 1'b0
`define PDWC_TOF_RESET 1'b0

`endif

/* pdwc_sync.v */
// Two-flop synchroniser for a bus of asynchronous inputs
`timescale 1ns/100ps
module pdwc_sync #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input wire ref_clk,
  input wire arst_n,
  // Data
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] stage1;

always @(posedge ref_clk or negedge arst_n) begin
  if (!arst_n) begin
    stage1 <= {WIDTH{1'b1}};
    sync_out <= {WIDTH{1'b1}};
  end else begin
    stage1 <= async_in;
    sync_out <= stage1;
  end
end

endmodule

/* testbench.sv */
// Self-checking testbench for the power-down mode controller
`timescale 1ns/100ps
`include "pdwc_regs.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; $display("MISMATCH %0t bad value", $time); end end
module testbench;
  reg ref_clk = 1'b0, arst_n = 1'b0, idle_select = 1'b0, idle_clock_keep = 1'b0, wdt_enable = 1'b0;
  reg stack_full = 1'b0, wdt_tick = 1'b0;
  reg [7:0] porta_pin = 8'hFF, porta_wake_enable = 8'h01;
  reg [3:0] int_request = 4'h0, int_enable = 4'h0;
  wire halt_exec, clr_wdt_exec, full_stop_sleep, watchdog_running_sleep, clock_off_idle, clock_on_idle, sys_clk_en;
  wire wdt_clk_en, tb_clk_en, core_hold, state_hold, wdt_overflow, powerdown_flag, watchdog_timeout_flag;
  wire resume_load, sp_reset, int_take;
  wire [11:0] halt_pc, resume_pc;
  wire [15:0] watchdog_counter;
  wire [2:0] sp_value;
  wire [3:0] int_pending;
  int errors = 0;
  int total_checks = 0;
  always #25 ref_clk = ~ref_clk;
  pdwc_core_model i_pdwc_core_model (.ref_clk, .halt_exec, .clr_wdt_exec, .halt_pc);
  pdwc_ctrl i_pdwc_ctrl (.ref_clk, .arst_n, .halt_exec, .clr_wdt_exec, .idle_select, .idle_clock_keep, .wdt_enable,
    .porta_pin, .porta_wake_enable, .int_request, .int_enable, .stack_full, .wdt_tick, .halt_pc, .full_stop_sleep,
    .watchdog_running_sleep, .clock_off_idle, .clock_on_idle, .sys_clk_en, .wdt_clk_en, .tb_clk_en, .core_hold,
    .state_hold, .watchdog_counter, .wdt_overflow, .powerdown_flag, .watchdog_timeout_flag, .resume_load,
    .resume_pc, .sp_reset, .sp_value, .int_take, .int_pending);
  task wait_wake(input int lim);
    int n;
    begin
      n = 0;
      while (resume_load !== 1'b1 && n < lim) begin
        @(posedge ref_clk) #1;
        n++;
      end
      `CHK(resume_load, 1'b1)
    end
  endtask
  task t_modes;
    reg [8:0] tbl [0:3];
    int i;
    begin
      tbl[0] = 9'b000_100000;
      tbl[1] = 9'b001_010000;
      tbl[2] = 9'b100_001001;
      tbl[3] = 9'b111_000111;
      for (i = 0; i < 4; i++) begin
        {idle_select, idle_clock_keep, wdt_enable} = tbl[i][8:6];
        wdt_tick = (i == 0);
        i_pdwc_core_model.halt(12'(12'h100 + i));
        `CHK({full_stop_sleep, watchdog_running_sleep, clock_off_idle, clock_on_idle, sys_clk_en, tb_clk_en}, tbl[i][5:0])
        `CHK({powerdown_flag, watchdog_timeout_flag, watchdog_counter, core_hold, state_hold}, 20'h80003)
        // A falling pin without its wake enable must be ignored
        porta_pin[1] = 1'b0;
        repeat (5) @(posedge ref_clk);
        #1 `CHK(core_hold, 1'b1)
        porta_pin[0] = 1'b0;
        wait_wake(8);
        `CHK(resume_pc, 12'(12'h101 + i))
        #1 porta_pin = 8'hFF;
        repeat (5) @(posedge ref_clk);
      end
      wdt_tick = 1'b0;
    end
  endtask
  task t_int;
    begin
      {idle_select, idle_clock_keep, wdt_enable} = 3'b110;
      int_request = 4'h2;
      int_enable = 4'h3;
      i_pdwc_core_model.halt(12'h200);
      repeat (4) @(posedge ref_clk);
      #1 `CHK(core_hold, 1'b1)
      int_request = 4'h3;
      wait_wake(4);
      `CHK({int_take, resume_pc}, 13'h1201)
      #1 int_request = 4'h0;
      int_enable = 4'h0;
      i_pdwc_core_model.halt(12'h300);
      int_request = 4'h4;
      wait_wake(4);
      `CHK({int_take, int_pending, resume_pc}, 17'h04301)
      #1 int_request = 4'h0;
      int_enable = 4'h4;
      @(posedge ref_clk) #1;
      `CHK({int_take, int_pending}, 5'h10)
      int_enable = 4'h0;
    end
  endtask
  task t_wdt;
    begin
      {idle_select, idle_clock_keep, wdt_enable} = 3'b001;
      i_pdwc_core_model.halt(12'h400);
      wdt_tick = 1'b1;
      wait_wake(66000);
      `CHK({watchdog_timeout_flag, powerdown_flag, sp_reset, resume_pc, sp_value}, 18'h38000)
      #1 wdt_tick = 1'b0;
      i_pdwc_core_model.clr_wdt;
      `CHK(powerdown_flag, 1'b0)
      i_pdwc_core_model.halt(12'h500);
      arst_n = 1'b0;
      @(posedge ref_clk) #1;
      arst_n = 1'b1;
      `CHK({core_hold, powerdown_flag, watchdog_timeout_flag, sys_clk_en}, 4'h1)
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    #1 arst_n = 1'b1;
    `CHK({powerdown_flag, watchdog_timeout_flag, sys_clk_en}, 3'b001)
    t_modes;
    t_int;
    t_wdt;
    end_of_test;
  end
  initial begin
    #4000000;
    errors++;
    end_of_test;
  end
endmodule
